/* src/xwd_consts.svh */
`ifndef XWD_CONSTS_SVH
`define XWD_CONSTS_SVH
// window count and address width
`define XWD_NWIN          3
`define XWD_AW            24
`define XWD_SA_W          12
`define XWD_SA_LSB        12
// periph_window_bus_cfg field positions
`define XWD_CYC_LSB       0
`define XWD_CYC_W         4
`define XWD_RWD_BIT       4
`define XWD_TRI_BIT       5
`define XWD_BTYP_LSB      6
`define XWD_EW_BIT        8
`define XWD_ALE_BIT       9
`define XWD_ACT_BIT       10
`define XWD_BSW_BIT       11
`define XWD_RDY_BIT       12
`define XWD_CFG_MASK      16'h1FFF
`define XWD_CFG_RST       16'h0000
`define XWD_ADR_RST       16'h0000
// size code limits
`define XWD_SZ_MAX        4'hB
`define XWD_BTYP_8        2'h0
`define XWD_BTYP_16       2'h2
`endif

/* src/xwd_pkg.sv */
package xwd_pkg;
  typedef enum logic [2:0] {
    XWD_IDLE = 3'b000,
    XWD_TURN = 3'b001,
    XWD_CYC  = 3'b011,
    XWD_DONE = 3'b010
  } xwd_state_e;
  typedef logic [15:0] xwd_word_t;
endpackage

/* src/xwd_window_match.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xwd_consts.svh"
module xwd_window_match (
  input  wire logic [15:0]          adr_sel,
  input  wire logic                 active,
  input  wire logic [`XWD_AW-1:0]   addr,
  output logic                      hit
);
  wire [3:0]            size_code = adr_sel[3:0];
  wire [11:0]           start     = adr_sel[15:4];
  // mask drops the bits inside the window, so bases align to size
  wire [11:0]           keep      = 12'hFFF << size_code;
  wire                  legal     = (size_code <= `XWD_SZ_MAX);
  assign hit = active && legal &&
               (((addr[23:12] ^ start) & keep) == 12'h000);
endmodule // xwd_window_match
`default_nettype wire

/* src/xwd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xwd_consts.svh"
// Notes on behaviour
// - size code 0..11 gives 4KB..8MB
// - base uses bits above size only
// - active bit enables window chip select
// - reset leaves all windows off, zero
// - bus type: 00 8-bit, 10 16-bit
// - early write ends strobe one clock sooner, in timed cycles only
// - switch control inserts one tri-state cycle
// - turnaround decided by the config left
// - ready bit: peripheral ends cycle, else count
// - timing fields pass as external bus fields
// - peripheral windows win over external windows
// - windows anywhere, smallest is 4KB
module xwd_top
  import xwd_pkg::*;
(
  input  wire logic                 REF_CLK,
  input  wire logic                 RST,
  input  wire logic [1:0]           CFG_SEL,
  input  wire logic                 CFG_WR_CFG,
  input  wire logic                 CFG_WR_ADR,
  input  wire xwd_pkg::xwd_word_t   CFG_WDATA,
  output xwd_pkg::xwd_word_t        CFG_RDATA_CFG,
  output xwd_pkg::xwd_word_t        CFG_RDATA_ADR,
  input  wire logic                 ACC_REQ,
  input  wire logic                 ACC_WR,
  input  wire logic [23:0]          ACC_ADDR,
  input  wire logic                 READY_N,
  output logic                      ACC_DONE,
  output logic                      ACC_PERIPH,
  output logic                      EXT_BUS_SEL,
  output logic [2:0]                PERIPH_CHIP_SELECT,
  output logic                      BUS_16BIT,
  output logic                      WR_STROBE,
  output logic                      BUS_TRISTATE,
  output logic                      LATCH_LENGTHEN,
  output logic                      RW_DELAY,
  output logic                      TRISTATE_TIME
);
  ////////////////////////////////////////////////////////////////////////////
  xwd_word_t  cfg_reg [3];
  xwd_word_t  adr_reg [3];
  xwd_word_t  last_cfg_reg;
  logic       last_valid_reg;
  xwd_state_e state_reg;
  xwd_state_e state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [1:0] win_reg;
  logic [2:0] hit;
  wire  [1:0] sel_i = (CFG_SEL > 2'd2) ? 2'd2 : CFG_SEL;

  // registers clear to zero, so every window starts disabled
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 3; i++) begin
        cfg_reg[i] <= `XWD_CFG_RST;
        adr_reg[i] <= `XWD_ADR_RST;
      end
    end else begin
      if (CFG_WR_CFG) cfg_reg[sel_i] <= CFG_WDATA & `XWD_CFG_MASK;
      if (CFG_WR_ADR) adr_reg[sel_i] <= CFG_WDATA;
    end
  end
  assign CFG_RDATA_CFG = cfg_reg[sel_i];
  assign CFG_RDATA_ADR = adr_reg[sel_i];

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_win
      xwd_window_match u_match (
        .adr_sel (adr_reg[g]),
        .active  (cfg_reg[g][`XWD_ACT_BIT]),
        .addr    (ACC_ADDR),
        .hit     (hit[g])
      );
    end
  endgenerate

  // overlapping windows are illegal; lowest index wins so select is one-hot
  wire [1:0] hit_idx = hit[0] ? 2'd0 : (hit[1] ? 2'd1 : 2'd2);
  wire       any_hit = |hit;
  xwd_word_t new_cfg;
  assign new_cfg = cfg_reg[hit_idx];
  xwd_word_t cur_cfg;
  assign cur_cfg = cfg_reg[win_reg];
  // turnaround taken from the old config's switch bit
  wire need_turn = last_valid_reg && (last_cfg_reg != new_cfg) &&
                   last_cfg_reg[`XWD_BSW_BIT];
  wire use_ready = cur_cfg[`XWD_RDY_BIT];
  wire [3:0] cyc_len = cur_cfg[`XWD_CYC_LSB +: `XWD_CYC_W];
  wire cyc_end = use_ready ? ~READY_N : (cnt_reg == cyc_len);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      XWD_IDLE: begin
        cnt_next = 4'h0;
        if (ACC_REQ && any_hit) begin
          state_next = need_turn ? XWD_TURN : XWD_CYC;
        end
      end
      XWD_TURN: state_next = XWD_CYC;
      XWD_CYC: begin
        if (cyc_end) begin
          state_next = XWD_DONE;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      XWD_DONE: state_next = XWD_IDLE;
      default:  state_next = XWD_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg      <= XWD_IDLE;
      cnt_reg        <= 4'h0;
      win_reg        <= 2'd0;
      last_cfg_reg   <= `XWD_CFG_RST;
      last_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (state_reg == XWD_IDLE && ACC_REQ && any_hit) win_reg <= hit_idx;
      if (state_reg == XWD_DONE) begin
        last_cfg_reg   <= cur_cfg;
        last_valid_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire in_cyc = (state_reg == XWD_CYC);
  // one clock is the finest step here, so the whole last timed cycle goes
  wire last_phase = ~use_ready && (cnt_reg == cyc_len);
  assign ACC_DONE    = (state_reg == XWD_DONE);
  // a peripheral hit hides every external window for this access
  assign ACC_PERIPH  = ACC_REQ && any_hit;
  assign EXT_BUS_SEL = ACC_REQ && !any_hit;
  assign BUS_TRISTATE = (state_reg == XWD_TURN);
  // reserved type codes fall back to 8-bit; software must avoid them
  assign BUS_16BIT = in_cyc &&
    (cur_cfg[`XWD_BTYP_LSB +: 2] == `XWD_BTYP_16);
  // early write drops the strobe in the last timed cycle
  assign WR_STROBE = in_cyc && ACC_WR &&
    !(cur_cfg[`XWD_EW_BIT] && last_phase);
  assign LATCH_LENGTHEN = in_cyc && cur_cfg[`XWD_ALE_BIT];
  assign RW_DELAY       = in_cyc && cur_cfg[`XWD_RWD_BIT];
  assign TRISTATE_TIME  = in_cyc && cur_cfg[`XWD_TRI_BIT];
  always_comb begin
    PERIPH_CHIP_SELECT = 3'b000;
    if (in_cyc) PERIPH_CHIP_SELECT[win_reg] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start_turn;
    state_reg == XWD_IDLE && ACC_REQ && any_hit && need_turn;
  endsequence
  sequence s_start_plain;
    state_reg == XWD_IDLE && ACC_REQ && any_hit && !need_turn;
  endsequence
  a_turn_inserted: assert property (
    @(posedge REF_CLK) disable iff (RST)
    s_start_turn |=> BUS_TRISTATE ##1 in_cyc)
    else $error("turnaround cycle missing");
  a_no_turn: assert property (
    @(posedge REF_CLK) disable iff (RST)
    s_start_plain |=> in_cyc)
    else $error("unexpected turnaround");
  a_cs_onehot: assert property (
    @(posedge REF_CLK) disable iff (RST)
    $onehot0(PERIPH_CHIP_SELECT) && (in_cyc == |PERIPH_CHIP_SELECT))
    else $error("chip select not one-hot");
  a_cs_active: assert property (
    @(posedge REF_CLK) disable iff (RST)
    in_cyc |-> cur_cfg[`XWD_ACT_BIT])
    else $error("select on disabled window");
  a_count_len: assert property (
    @(posedge REF_CLK) disable iff (RST)
    in_cyc && !use_ready && cnt_reg == cyc_len |=> ACC_DONE)
    else $error("timed cycle length wrong");
  a_ready_end: assert property (
    @(posedge REF_CLK) disable iff (RST)
    in_cyc && use_ready && READY_N |=> !ACC_DONE)
    else $error("ended without ready");
  a_periph_first: assert property (
    @(posedge REF_CLK) disable iff (RST)
    ACC_REQ && any_hit |-> ACC_PERIPH && !EXT_BUS_SEL)
    else $error("external chosen over window");
  a_reset_off: assert property (
    @(posedge REF_CLK)
    $fell(RST) |-> hit == 3'b000)
    else $error("window enabled after reset");
  a_early_write: assert property (
    @(posedge REF_CLK) disable iff (RST)
    in_cyc && ACC_WR && !cur_cfg[`XWD_EW_BIT] |-> WR_STROBE)
    else $error("strobe cut without early write");
  a_early_cut: assert property (
    @(posedge REF_CLK) disable iff (RST)
    in_cyc && cur_cfg[`XWD_EW_BIT] && last_phase |-> !WR_STROBE)
    else $error("early write strobe not cut");
  a_width_16: assert property (
    @(posedge REF_CLK) disable iff (RST)
    in_cyc && cur_cfg[7:6] == 2'b00 |-> !BUS_16BIT)
    else $error("8-bit window drove 16-bit");
endmodule // xwd_top
`default_nettype wire

/* testbench/xwd_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
module xwd_periph_model (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic [2:0] chip_sel,
  input  wire logic [3:0] delay,
  output logic            READY_N
);
  logic [3:0] cnt_reg;
  // released line reads high, as the ready input is pulled up
  assign READY_N = !((chip_sel != 3'h0) && (cnt_reg == delay));
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) cnt_reg <= 4'h0;
    else cnt_reg <= (chip_sel != 3'h0) ? cnt_reg + 4'h1 : 4'h0;
  end
endmodule // xwd_periph_model
`default_nettype wire

/* testbench/xwd_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module xwd_top_test;
  import xwd_pkg::*;
  logic       REF_CLK = 1'b0, RST = 1'b1, ACC_REQ = 1'b0, ACC_WR = 1'b0;
  logic       CFG_WR_CFG = 1'b0, CFG_WR_ADR = 1'b0, READY_N;
  logic [1:0] CFG_SEL = 2'h0;
  logic [23:0] ACC_ADDR = 24'h00_0000;
  logic [3:0] pd = 4'h0;
  xwd_word_t  CFG_WDATA = 16'h0000, CFG_RDATA_CFG, CFG_RDATA_ADR;
  logic       ACC_DONE, ACC_PERIPH, EXT_BUS_SEL, BUS_16BIT, WR_STROBE;
  logic       BUS_TRISTATE, LATCH_LENGTHEN, RW_DELAY, TRISTATE_TIME;
  logic [2:0] PERIPH_CHIP_SELECT;
  logic [31:0] seed = 32'h0256_6045, r;
  logic [18:0] q[$];
  logic [4:0] ln = 5'h0, st = 5'h0;
  logic [1:0] tn = 2'h0;
  logic [6:0] fl = 7'h0;
  logic [15:0] cf[3];
  logic [23:0] ba[3];
  int         failures, n_tests, pw, i, j, k, w;
  always #20 REF_CLK = ~REF_CLK;
  xwd_top DUT (.REF_CLK(REF_CLK), .RST(RST), .CFG_SEL(CFG_SEL),
    .CFG_WR_CFG(CFG_WR_CFG), .CFG_WR_ADR(CFG_WR_ADR), .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA_CFG(CFG_RDATA_CFG), .CFG_RDATA_ADR(CFG_RDATA_ADR),
    .ACC_REQ(ACC_REQ), .ACC_WR(ACC_WR), .ACC_ADDR(ACC_ADDR),
    .READY_N(READY_N), .ACC_DONE(ACC_DONE), .ACC_PERIPH(ACC_PERIPH),
    .EXT_BUS_SEL(EXT_BUS_SEL), .PERIPH_CHIP_SELECT(PERIPH_CHIP_SELECT),
    .BUS_16BIT(BUS_16BIT), .WR_STROBE(WR_STROBE), .BUS_TRISTATE(BUS_TRISTATE),
    .LATCH_LENGTHEN(LATCH_LENGTHEN), .RW_DELAY(RW_DELAY),
    .TRISTATE_TIME(TRISTATE_TIME));
  xwd_periph_model PM (.REF_CLK(REF_CLK), .RST(RST),
    .chip_sel(PERIPH_CHIP_SELECT), .delay(pd), .READY_N(READY_N));
  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task summarize;
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmp_reg(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t: flag/reg got %h want %h", $time, g, e);
    end
  endtask
  task cmp_acc(input logic [18:0] e, input logic [18:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t: cycle got %h want %h", $time, g, e);
    end
  endtask
  task wr(input int s, input logic [15:0] c, input logic [15:0] a);
    @(negedge REF_CLK);
    CFG_SEL = s[1:0];
    CFG_WDATA = c;
    CFG_WR_CFG = 1'b1;
    @(negedge REF_CLK);
    CFG_WR_CFG = 1'b0;
    CFG_WDATA = a;
    CFG_WR_ADR = 1'b1;
    @(negedge REF_CLK);
    CFG_WR_ADR = 1'b0;
    cmp_reg(c & 16'h1FFF, CFG_RDATA_CFG);
    cmp_reg(a, CFG_RDATA_ADR);
  endtask
  // probe decode only: request is dropped before the next rising edge
  task pr(input logic [23:0] a, input logic h);
    @(negedge REF_CLK);
    ACC_ADDR = a;
    ACC_REQ = 1'b1;
    #1 cmp_reg({14'h0, h, ~h},
      {14'h0, ACC_PERIPH, EXT_BUS_SEL});
    #1 ACC_REQ = 1'b0;
  endtask
  task acc(input int w, input logic [23:0] a, input logic [1:0] t);
    logic [4:0] l;
    logic       wv;
    l = {1'b0, cf[w][12] ? pd : cf[w][3:0]} + 5'h1;
    wv = seed[9];
    q.push_back({wv ? l - {4'h0, cf[w][8] & ~cf[w][12]} : 5'h0, l, t,
      cf[w][5], cf[w][4], cf[w][9], cf[w][7], 3'h1 << w});
    @(negedge REF_CLK);
    ACC_ADDR = a;
    ACC_WR = wv;
    ACC_REQ = 1'b1;
    for (i = 0; i < 60 && ACC_DONE !== 1'b1; i++) @(negedge REF_CLK);
    if (i == 60) begin
      failures++;
      $display("mismatch %0t: access timed out", $time);
    end
    ACC_REQ = 1'b0;
    pw = w;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge REF_CLK) begin
    if (PERIPH_CHIP_SELECT != 3'h0) begin
      ln = ln + 5'h1;
      fl = fl | {TRISTATE_TIME, RW_DELAY, LATCH_LENGTHEN, BUS_16BIT,
        PERIPH_CHIP_SELECT};
    end
    if (WR_STROBE === 1'b1) st = st + 5'h1;
    if (BUS_TRISTATE === 1'b1) tn = tn + 2'h1;
    if (ACC_DONE === 1'b1) begin
      cmp_acc(q.size() ? q.pop_front() : 19'h7_FFFF,
        {st, ln, tn, fl});
      ln = 5'h0;
      st = 5'h0;
      tn = 2'h0;
      fl = 7'h0;
    end
  end
  initial begin
    failures = 0;
    n_tests = 0;
    pw = -1;
    repeat (8) @(posedge REF_CLK);
    @(negedge REF_CLK) RST = 1'b0;
    for (w = 0; w < 3; w++) begin
      @(negedge REF_CLK) CFG_SEL = w[1:0];
      #1 cmp_reg(16'h0000, CFG_RDATA_CFG | CFG_RDATA_ADR);
    end
    pr(24'h10_0000, 1'b0);
    // low start bits are random junk that alignment must drop
    for (k = 0; k < 12; k++) begin
      r = xs();
      wr(2, 16'h0400, {12'h800 | (r[11:0] & ((12'h1 << k) - 12'h1)), k[3:0]});
      pr(24'h80_0000 + (24'h1000 << k) - 24'h1, 1'b1);
      pr(24'h80_0000 + (24'h1000 << k), 1'b0);
      pr(24'h7F_FFFF, 1'b0);
    end
    wr(2, 16'h0000, 16'h8000);
    pr(24'h80_0000, 1'b0);
    // reserved size and type codes are never written
    cf[0] = 16'h0FB0 | {12'h000, r[3:0]};
    cf[1] = 16'h1400;
    cf[2] = 16'h0480;
    ba[0] = 24'h10_0000;
    ba[1] = 24'h10_1000;
    ba[2] = 24'h80_0000;
    wr(0, cf[0], 16'h1000);
    wr(1, cf[1], 16'h1001);
    wr(2, cf[2], 16'h8000);
    // a timed-out access stops the traffic and goes on to the report
    for (j = 0; j < 20 && i < 60; j++) begin
      r = xs();
      w = (j < 2) ? 0 : ((j < 4) ? j - 1 : int'(r[31:24]) % 3);
      pd = {2'h0, r[17:16]};
      acc(w, ba[w] + {12'h000, r[11:0]},
        (pw >= 0 && pw != w && cf[pw][11]) ? 2'h1 : 2'h0);
    end
    @(negedge REF_CLK) RST = 1'b1;
    @(negedge REF_CLK) RST = 1'b0;
    #1 cmp_reg(16'h0000, CFG_RDATA_CFG | CFG_RDATA_ADR);
    summarize();
  end
endmodule // xwd_top_test
`default_nettype wire
